// file: rtl/pswr_host.sv
// Purpose: host controller driving an asynchronous pseudo-static ram
//          one access at a time, write or read, 16-bit words
// Assumes: pins settle within a clock; data bus inputs sampled on clk
//          slow grade windows throughout, which also cover the fast grade
// Notes:   every access deselects afterwards so the hidden refresh runs
//          a write strobe never stays low for more than a few cycles
`timescale 1ns/1ps
// How it works
// - write only while all strobes active
// - data set up before end, held after
// - address stable long before write end
// - address may change as write ends
// - lane enables valid long before end
// - reads spaced at least a read cycle
// - no single write beyond refresh window
// - long write bursts broken by gaps
// - write strobe high during reads
module pswr_host (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire pswr_pkg::pswr_req_t           req,
	input  wire logic                          req_valid,
	output logic                               req_ready,
	output logic [pswr_pkg::DATA_W-1:0]        rdata_ff,
	output logic                               rdata_valid_ff,
	output pswr_pkg::pswr_pins_t               pins,
	input  wire logic [pswr_pkg::DATA_W-1:0]   dq_in
);
	// access phases: setup, strobe low, read window, bus turnaround and
	// the deselected gap that lets the hidden refresh run
	typedef enum logic [2:0] {
		PSWR_IDLE, PSWR_WSET, PSWR_WLOW, PSWR_RLOW, PSWR_TURN, PSWR_GAP
	} pswr_state_t;

	pswr_state_t                   state_ff;     // access sequencer
	pswr_state_t                   nxt_state;
	logic [9:0]                    cnt_ff;       // cycles left in phase
	logic [9:0]                    nxt_cnt;
	pswr_pkg::pswr_req_t           cur_ff;       // latched request
	logic                          sel_ff;       // chip selected
	logic                          we_low_ff;    // write strobe low
	logic                          oe_low_ff;    // output enable low
	logic                          dq_oe_ff;     // host drives data
	logic                          wr_end;       // last strobe low cycle
	logic                          rd_done;      // last output enable cycle
	logic [1:0]                    lane_pin_n;   // lane enables at the pins

	// ready only when idle so address is never changed mid access
	assign req_ready = (state_ff == PSWR_IDLE);

	// end of the write strobe: the pins leave the write on the next edge
	assign wr_end = (state_ff == PSWR_WLOW) && (cnt_ff == pswr_pkg::CNT_ZERO);
	// end of the read window: data has stood on the bus for the full access
	assign rd_done = (state_ff == PSWR_RLOW) && (cnt_ff == pswr_pkg::CNT_ZERO);

	// next state and phase counter; the counter loads one less than the
	// phase length because the loading edge is itself the first cycle
	// of the phase
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = (cnt_ff != pswr_pkg::CNT_ZERO) ? cnt_ff - 10'h001 : cnt_ff;
		case (state_ff)
			// idle: deselected, waiting for a request
			PSWR_IDLE: begin
				if (req_valid) begin
					// one setup cycle puts address and lanes ahead of strobe
					nxt_state = PSWR_WSET;
					nxt_cnt = pswr_pkg::CNT_ZERO;
				end
			end
			// setup: selected, address and lanes settle before any strobe
			PSWR_WSET: begin
				if (cur_ff.write) begin
					nxt_state = PSWR_WLOW;
					nxt_cnt = pswr_pkg::WR_LOW_CNT - 10'h001;
				end else begin
					nxt_state = PSWR_RLOW;
					nxt_cnt = pswr_pkg::RD_CNT - 10'h001;
				end
			end
			// write: strobe low for the counted pulse
			PSWR_WLOW: begin
				// strobe pulse is bounded far below refresh window
				if (cnt_ff == pswr_pkg::CNT_ZERO) begin
					nxt_state = PSWR_GAP;
					nxt_cnt = pswr_pkg::GAP_CNT - 10'h001;
				end
			end
			// read: output enable low for one full read cycle
			PSWR_RLOW: begin
				if (cnt_ff == pswr_pkg::CNT_ZERO) begin
					nxt_state = PSWR_TURN;
					nxt_cnt = pswr_pkg::TURN_CNT - 10'h001;
				end
			end
			// turnaround: device lets go of the data bus
			PSWR_TURN: begin
				// wait for device to release bus before next write
				if (cnt_ff == pswr_pkg::CNT_ZERO) begin
					nxt_state = PSWR_GAP;
					nxt_cnt = pswr_pkg::GAP_CNT - 10'h001;
				end
			end
			// gap: deselected break before the next access
			PSWR_GAP: begin
				// deselected gap lets refresh run between accesses
				if (cnt_ff == pswr_pkg::CNT_ZERO) begin
					nxt_state = PSWR_IDLE;
				end
			end
			// unused codes fall back to idle
			default: begin
				nxt_state = PSWR_IDLE;
			end
		endcase
	end

	// state register; reset lands in idle with a cleared counter so the
	// first request after reset is taken on the first edge
	// state and counter always move together
	always_ff @(posedge clk) begin
		if (rst) begin
			state_ff <= PSWR_IDLE;
			cnt_ff <= pswr_pkg::CNT_ZERO;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
		end
	end

	// request capture, held stable through the access
	// address, lanes and data stay put from the setup cycle to the end of
	// the gap, which gives the long setup windows with room to spare
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_ff <= '0;
			cur_ff.lane_n <= pswr_pkg::LANES_OFF;
		end else if (req_ready && req_valid) begin
			cur_ff <= req;
		end
	end

	// chip select: both polarities come from this one flop, so they
	// switch together and never leave a half selected window
	always_ff @(posedge clk) begin
		if (rst) begin
			sel_ff <= 1'b0; // deselected out of reset
		end else begin
			sel_ff <= (nxt_state == PSWR_WSET) || (nxt_state == PSWR_WLOW) ||
				(nxt_state == PSWR_RLOW);
		end
	end

	// write strobe is the single terminating edge; it rises together
	// with the select, so whichever the device sees first ends the write
	always_ff @(posedge clk) begin
		if (rst) begin
			we_low_ff <= 1'b0; // strobe idles high
		end else begin
			we_low_ff <= (nxt_state == PSWR_WLOW);
		end
	end

	// output enable low only inside the read window
	always_ff @(posedge clk) begin
		if (rst) begin
			oe_low_ff <= 1'b0; // device kept off the bus
		end else begin
			oe_low_ff <= (nxt_state == PSWR_RLOW);
		end
	end

	// data driven with the strobe and held one cycle past its end;
	// the extra cycle costs nothing and covers the zero hold window
	always_ff @(posedge clk) begin
		if (rst) begin
			dq_oe_ff <= 1'b0; // bus released out of reset
		end else begin
			dq_oe_ff <= (nxt_state == PSWR_WLOW) || wr_end;
		end
	end

	// read data taken at the end of the access window, kept until next read
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_ff <= 16'h0000;
		end else if (rd_done) begin
			rdata_ff <= dq_in;
		end
	end

	// one cycle pulse telling the user that rdata_ff is fresh
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata_valid_ff <= 1'b0;
		end else begin
			rdata_valid_ff <= rd_done;
		end
	end

	// lane enables, one per byte; gated by the select so both lanes idle
	// high outside accesses and a stale lane never qualifies a write
	for (genvar g = 0; g < 2; g++) begin : g_lane
		assign lane_pin_n[g] = sel_ff ? cur_ff.lane_n[g] : 1'b1;
	end

	// pin assembly; every strobe comes from a flop, so no glitches
	always_comb begin
		pins.chip_sel_low_n = ~sel_ff;
		pins.chip_sel_high = sel_ff;
		pins.we_n = ~we_low_ff;
		pins.oe_n = ~oe_low_ff;
		pins.upper_lane_n = lane_pin_n[1];
		pins.lower_lane_n = lane_pin_n[0];
		pins.addr = cur_ff.addr;
		pins.dq_out = cur_ff.wdata;
		pins.dq_oe = dq_oe_ff;
	end
endmodule : pswr_host

// file: common/pswr_pkg.sv
// Purpose: constants and carriers for the pseudo-static ram write/read host
// Assumes: 50 MHz clock, slow speed grade timing used throughout
// Notes:   times kept in ns as printed, cycle counts derived below
package pswr_pkg;
	localparam int CLK_NS = 20; // clock period in ns
	// least times round up, longest times round down
	localparam int T_DATA_SETUP_NS = 30; // data_setup_to_end, slow grade
	localparam int T_DATA_HOLD_NS = 0; // data_hold_after_end
	localparam int T_ADDR_SETUP_NS = 60; // address setup to write end
	localparam int T_ADDR_HOLD_NS = 0; // addr_hold_after_end
	localparam int T_LANE_VALID_NS = 60; // lane_valid_to_end
	localparam int T_WE_PULSE_NS = 60; // write strobe width
	localparam int T_HIZ_NS = 30; // strobe fall to device release
	localparam int T_DRIVE_NS = 5; // strobe_to_drive
	localparam int T_GAP_NS = 5; // break between writes
	localparam int T_READ_CYC_NS = 70; // read cycle time
	localparam int T_ACCESS_NS = 70; // read access time
	localparam int T_REFRESH_NS = 15000; // refresh window
	localparam int T_RD_HIZ_NS = 25; // output release after read

	function automatic int cyc_up(input int ns);
		int c;
		c = (ns + CLK_NS - 1) / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_up

	function automatic int cyc_dn(input int ns);
		int c;
		c = ns / CLK_NS;
		return (c < 1) ? 1 : c;
	endfunction : cyc_dn

	// write low time must cover the pulse width and the release plus data setup windows
	localparam int WR_PULSE_CYC = cyc_up(T_WE_PULSE_NS);
	localparam int WR_DATA_CYC = cyc_up(T_HIZ_NS + T_DATA_SETUP_NS);
	localparam int WR_LOW_CYC = (WR_PULSE_CYC > WR_DATA_CYC) ? WR_PULSE_CYC : WR_DATA_CYC;
	localparam int GAP_CYC = cyc_up(T_GAP_NS);
	localparam int RD_CYC = cyc_up(T_READ_CYC_NS);
	localparam int RD_ACCESS_CYC = cyc_up(T_ACCESS_NS);
	localparam int RD_TURN_CYC = cyc_up(T_RD_HIZ_NS);
	localparam int REFRESH_CYC = cyc_dn(T_REFRESH_NS);
	localparam logic [9:0] WR_LOW_CNT = 10'(WR_LOW_CYC);
	localparam logic [9:0] RD_CNT = 10'(RD_CYC);
	localparam logic [9:0] TURN_CNT = 10'(RD_TURN_CYC);
	localparam logic [9:0] GAP_CNT = 10'(GAP_CYC);
	localparam logic [9:0] CNT_ZERO = 10'h000;

	localparam int ADDR_W = 19; // 512K words
	localparam int DATA_W = 16;

	// user request
	typedef struct packed {
		logic              write;  // 1 write, 0 read
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0]        lane_n; // [1] upper, [0] lower, low active
	} pswr_req_t;

	// memory pins, outputs of the host
	typedef struct packed {
		logic              chip_sel_low_n;
		logic              chip_sel_high;
		logic              we_n;
		logic              oe_n;
		logic              upper_lane_n;
		logic              lower_lane_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_out;
		logic              dq_oe;
	} pswr_pins_t;

	localparam logic [1:0] LANES_OFF = 2'h3;
endpackage : pswr_pkg

// file: test/pswr_host_monitor.sv
// Purpose: pin timing checks on the psram host
// Assumes: 20 ns clock, three-cycle write strobe
// Notes:   sees host ports only
`timescale 1ns/1ps
module pswr_host_monitor (
	input wire logic                 clk,
	input wire logic                 rst,
	input wire pswr_pkg::pswr_req_t  req,
	input wire logic                 req_valid,
	input wire logic                 req_ready,
	input wire logic [15:0]          rdata_ff,
	input wire logic                 rdata_valid_ff,
	input wire pswr_pkg::pswr_pins_t pins,
	input wire logic [15:0]          dq_in
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// three low cycles give the 60 ns windows
	sequence s_wr_low; !pins.we_n [*3]; endsequence
	sequence s_rd_low; !pins.oe_n [*4]; endsequence
	property p_sel; !pins.we_n |-> !pins.chip_sel_low_n && pins.chip_sel_high; endproperty
	property p_wlen; $fell(pins.we_n) |-> s_wr_low ##1 pins.we_n; endproperty
	property p_addr; $fell(pins.we_n) |->
		$stable({pins.addr, pins.upper_lane_n, pins.lower_lane_n}) [*3]; endproperty
	property p_data; $fell(pins.we_n) |-> ##1 (pins.dq_oe && $stable(pins.dq_out)) [*3]; endproperty
	property p_gap; $rose(pins.we_n) |-> pins.chip_sel_low_n; endproperty
	property p_busy; !pins.we_n |-> !req_ready; endproperty
	property p_rdwe; !pins.oe_n |-> pins.we_n; endproperty
	property p_rlen; $fell(pins.oe_n) |-> s_rd_low ##1 (pins.oe_n && rdata_valid_ff); endproperty
	a_sel: assert property (p_sel) else $error("write unselected");
	a_wlen: assert property (p_wlen) else $error("write length");
	a_addr: assert property (p_addr) else $error("address moved");
	a_data: assert property (p_data) else $error("data moved");
	a_gap: assert property (p_gap) else $error("no deselect gap");
	a_busy: assert property (p_busy) else $error("taken mid write");
	a_rdwe: assert property (p_rdwe) else $error("strobe in read");
	a_rlen: assert property (p_rlen) else $error("read cycle");
endmodule : pswr_host_monitor

// file: test/pswr_mem_model.sv
// Purpose: behavioural psram seen from its pins
// Assumes: pins move just after clk edges
// Notes:   clk only paces the model; the part has none
`timescale 1ns/1ps
module pswr_mem_model (
	input wire logic                 clk,
	input wire pswr_pkg::pswr_pins_t pins,
	output logic [15:0]              dq_in
);
	logic [15:0] mem [logic [18:0]]; // sparse, unwritten reads zero
	logic        sel;                // both selects active
	logic        wr;                 // internal write overlap
	int          starve;             // cycles with no refresh chance
	assign sel = !pins.chip_sel_low_n && pins.chip_sel_high;
	assign wr = sel && !pins.we_n && !(pins.upper_lane_n && pins.lower_lane_n);
	initial dq_in = 16'h0000;
	// lanes written alone; a starved refresh loses everything
	always @(posedge clk) begin
		if (wr && !mem.exists(pins.addr)) mem[pins.addr] = 16'h0000;
		if (wr && !pins.upper_lane_n) mem[pins.addr][15:8] = pins.dq_out[15:8];
		if (wr && !pins.lower_lane_n) mem[pins.addr][7:0] = pins.dq_out[7:0];
		starve = wr ? starve + 1 : 0;
		if (starve > pswr_pkg::REFRESH_CYC) mem.delete();
		// released bus flips so a stale value never passes
		if (sel && pins.we_n && !pins.oe_n && mem.exists(pins.addr)) dq_in <= mem[pins.addr];
		else if (sel && pins.we_n && !pins.oe_n) dq_in <= 16'h0000;
		else dq_in <= ~dq_in;
	end
endmodule : pswr_mem_model

// file: test/pswr_host_test.sv
// Purpose: corner and random traffic through the psram host
// Assumes: host timing as handed over
// Notes:   bench keeps eight word slots
`timescale 1ns/1ps
module pswr_host_test;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	pswr_pkg::pswr_req_t  req = '0;
	logic                 req_valid = 1'b0;
	logic                 req_ready;
	logic [15:0]          rdata_ff;
	logic                 rdata_valid_ff;
	pswr_pkg::pswr_pins_t pins;
	logic [15:0]          dq_in;
	logic [15:0]          exp_mem [8] = '{default: 16'h0000}; // bench copy
	int                   err_count = 0;
	int                   samples_checked = 0;
	int                   seed = 28228;
	always #10 clk = ~clk;
	pswr_host i_pswr_host (.clk(clk), .rst(rst), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .rdata_ff(rdata_ff), .rdata_valid_ff(rdata_valid_ff),
		.pins(pins), .dq_in(dq_in));
	pswr_mem_model i_pswr_mem_model (.clk(clk), .pins(pins), .dq_in(dq_in));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : finish_test
	// bytes with a high lane enable keep the old value
	function automatic logic [15:0] merge(input logic [15:0] o, n, input logic [1:0] l);
		return {l[1] ? o[15:8] : n[15:8], l[0] ? o[7:0] : n[7:0]};
	endfunction : merge
	// bounded wait; a hang counts as a mismatch
	task automatic wait_for(input bit rd);
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			if ((rd ? rdata_valid_ff : req_ready) === 1'b1) return;
		end
		err_count++;
		finish_test();
	endtask : wait_for
	task automatic access(input logic w, input logic [2:0] s, input logic [15:0] d,
		input logic [1:0] l);
		wait_for(0);
		@(posedge clk);
		req <= {w, s, 16'hffff, d, l};
		req_valid <= 1'b1;
		@(posedge clk);
		req_valid <= 1'b0;
		if (w) exp_mem[s] = merge(exp_mem[s], d, l);
		else begin
			wait_for(1);
			check(rdata_ff, exp_mem[s]);
		end
	endtask : access
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check({12'h000, pins.chip_sel_low_n, pins.chip_sel_high, pins.we_n, pins.dq_oe}, 16'h000a);
		// top slot, each lane alone, no lane, reads right behind writes
		access(1, 3'h7, 16'ha5c3, 2'h0);
		access(0, 3'h7, 16'h0000, 2'h0);
		access(1, 3'h7, 16'h1e2d, 2'h1);
		access(1, 3'h7, 16'h3c4b, 2'h2);
		access(1, 3'h7, 16'hffff, 2'h3);
		access(0, 3'h7, 16'h0000, 2'h0);
		$display("corner test done");
		// long run keeps data alive past the refresh window
		for (int n = 0; n < 200; n++)
			access(1'($random(seed)), 3'($random(seed)), 16'($random(seed)), 2'($random(seed)));
		$display("random test done");
		finish_test();
	end
endmodule : pswr_host_test
bind pswr_host pswr_host_monitor i_pswr_host_monitor (.clk(clk), .rst(rst), .req(req),
	.req_valid(req_valid), .req_ready(req_ready), .rdata_ff(rdata_ff),
	.rdata_valid_ff(rdata_valid_ff), .pins(pins), .dq_in(dq_in));
